// File: include/lssa_pkg.sv
// Shared constants and types for the AND, stack-align and shift execution block
package lssa_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_OPCODE = 8'h00;
    localparam logic [7:0] OFS_IMMW   = 8'h04;
    localparam logic [7:0] OFS_MEMOP  = 8'h08;
    localparam logic [7:0] OFS_ACC    = 8'h0C;
    localparam logic [7:0] OFS_PROD   = 8'h10;
    localparam logic [7:0] OFS_MCAND  = 8'h14;
    localparam logic [7:0] OFS_SP     = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_REPEAT = 8'h20;

    // Status register bit positions
    localparam int ST_C     = 0;
    localparam int ST_Z     = 1;
    localparam int ST_N     = 2;
    localparam int ST_ALIGN = 3;
    localparam int ST_BUSY  = 4;
    localparam int ST_ILL   = 5;

    // Values after reset
    localparam logic [31:0] RST_ACC    = 32'h0000_0000;
    localparam logic [31:0] RST_PROD   = 32'h0000_0000;
    localparam logic [31:0] RST_MCAND  = 32'h0000_0000;
    localparam logic [15:0] RST_SP     = 16'h0000;
    localparam logic [15:0] RST_MEMOP  = 16'h0000;
    localparam logic [15:0] RST_IMMW   = 16'h0000;
    localparam logic [15:0] RST_REPEAT = 16'h0000;
    localparam logic [15:0] RST_OPCODE = 16'h0000;

    // Opcode patterns and the bits that must match
    localparam logic [15:0] PAT_AND_TO_MEM  = 16'hC000;
    localparam logic [15:0] MSK_AND_TO_MEM  = 16'hFE00;
    localparam logic [15:0] PAT_AND_TO_HALF = 16'hCE00;
    localparam logic [15:0] MSK_AND_TO_HALF = 16'hFE00;
    localparam logic [15:0] PAT_AND_IMM_MEM = 16'h1800;
    localparam logic [15:0] MSK_AND_IMM_MEM = 16'hFF00;
    localparam logic [15:0] PAT_AND_BYTE    = 16'h9000;
    localparam logic [15:0] MSK_AND_BYTE    = 16'hFE00;
    localparam logic [15:0] PAT_ALIGN       = 16'h761B;
    localparam logic [15:0] PAT_ASR_IMM     = 16'hFFA0;
    localparam logic [15:0] MSK_ASR_IMM     = 16'hFFE0;
    localparam logic [15:0] PAT_ASR_CNT     = 16'hFF64;
    localparam logic [15:0] MSK_ASR_CNT     = 16'hFFFE;
    localparam logic [15:0] PAT_ASR_WIDE    = 16'h5680;
    localparam logic [15:0] MSK_ASR_WIDE    = 16'hFFF0;

    // Field positions inside the opcode and the multiplicand register
    localparam int HI_BIT_AND     = 8;
    localparam int HI_BIT_ASR_IMM = 4;
    localparam int HI_BIT_ASR_CNT = 0;
    localparam int T_CNT_LO       = 16;

    // Bus answer
    localparam logic RESP_OKAY = 1'b0;

    // Decoded operation
    typedef enum logic [3:0] {
        OP_NONE,
        OP_AND_TO_MEM,
        OP_AND_TO_HALF,
        OP_AND_IMM_MEM,
        OP_AND_BYTE,
        OP_ALIGN,
        OP_ASR_IMM,
        OP_ASR_CNT,
        OP_ASR_WIDE,
        OP_ILLEGAL
    } lssa_op_t;

endpackage

// File: src/lssa_asr.sv
// Arithmetic right shifter with last-bit-out carry
`timescale 1ns/1ps
module lssa_asr #(
    parameter int W  = 16,
    parameter int AW = 5
) (
    // Operand and amount
    input  wire logic [W-1:0]  value_in,
    input  wire logic [AW-1:0] amount,
    // Result
    output logic [W-1:0]       result,
    output logic               carry
);
    logic signed [W:0] ext;

    // One guard bit below the value catches the last bit out; zero amount gives zero carry
    assign ext    = $signed({value_in, 1'b0}) >>> amount;
    assign result = ext[W:1];
    assign carry  = ext[0];
endmodule

// File: src/lssa_core.sv
// AND, stack-align and arithmetic shift execution block with AHB-Lite registers
// What this block does
// - AND half into memory operand, written back as one read-modify-write
// - Memory result: N is bit 15, Z set only when stored value is zero
// - AND memory operand into selected half, only that half written
// - Half result: N is bit 15, Z set only when that half is zero
// - AND memory operand with following constant word, stored back to memory
// - Byte form: zero-extend low opcode byte, AND into selected half
// - Align: odd pointer incremented and flag set; even pointer kept, flag cleared
// - Align flag update commits in the second decode stage
// - Immediate half shift: sign fill, carry takes last bit shifted out
// - Register-count half shift uses multiplicand bits 3:0 of upper word only
// - Zero count clears carry; nonzero loads carry with last bit out
// - Zero count still updates N and Z from the half
// - Wide shift: accumulator:product shifted right, sign filled, carry last out
// - Wide shift: N is accumulator bit 31, Z when all 64 bits zero
// - Repeat prefix ignored: repeat counter cleared (kept on an illegal opcode), instruction runs once
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module lssa_core
    import lssa_pkg::*;
#(
    parameter int SHAMT_W = 5
) (
    // Clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP
);
    // Bus state
    logic        wr_pend_reg, wr_pend_next;
    logic        rd_pend_reg, rd_pend_next;
    logic [7:0]  addr_reg, addr_next;
    logic        ready_reg, ready_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        resp_reg;
    // Decode stage
    lssa_op_t    d1_op_reg, d1_op_next;
    logic        d1_hi_reg, d1_hi_next;
    logic [15:0] opcode_reg, opcode_next;
    // Architectural state
    logic [31:0] acc_reg, acc_next;
    logic [31:0] prod_reg, prod_next;
    logic [31:0] multiplicand_full_reg, multiplicand_full_next;
    logic [15:0] sp_reg, sp_next;
    logic [15:0] memop_reg, memop_next;
    logic [15:0] immw_reg, immw_next;
    logic [15:0] repeat_counter_reg, repeat_counter_next;
    logic        c_reg, c_next;
    logic        z_reg, z_next;
    logic        n_reg, n_next;
    logic        stack_align_flag_reg, stack_align_flag_next;
    logic        ill_reg, ill_next;
    // Datapath helpers
    logic               accept;
    logic               bus_wr;
    logic               fire;
    logic               op_wr;
    logic [15:0]        half_cur;
    logic [15:0]        and_res;
    logic [SHAMT_W-1:0] half_amt;
    logic [SHAMT_W-1:0] wide_amt;
    logic [15:0]        half_shr;
    logic               half_cy;
    logic [63:0]        wide_shr;
    logic               wide_cy;
    logic [31:0]        read_mux;
    lssa_op_t           dec_op;
    logic               dec_hi;

    // Address phase taken when selected, active and the bus is ready
    assign accept   = HSEL & HTRANS[1] & HREADY;
    assign bus_wr   = wr_pend_reg & CE;
    assign op_wr    = bus_wr & (addr_reg == OFS_OPCODE);
    assign fire     = (d1_op_reg != OP_NONE) & CE;
    assign half_cur = d1_hi_reg ? acc_reg[31:16] : acc_reg[15:0];

    // Immediate field is amount minus one; count form reads T bits 3:0 only
    assign half_amt = (d1_op_reg == OP_ASR_IMM) ?
                      SHAMT_W'({1'b0, opcode_reg[3:0]}) + SHAMT_W'(1) :
                      SHAMT_W'(multiplicand_full_reg[T_CNT_LO +: 4]);
    assign wide_amt = SHAMT_W'({1'b0, opcode_reg[3:0]}) + SHAMT_W'(1);

    lssa_asr #(.W(16), .AW(SHAMT_W)) u_half_asr (
        .value_in (half_cur),
        .amount   (half_amt),
        .result   (half_shr),
        .carry    (half_cy)
    );

    lssa_asr #(.W(64), .AW(SHAMT_W)) u_wide_asr (
        .value_in ({acc_reg, prod_reg}),
        .amount   (wide_amt),
        .result   (wide_shr),
        .carry    (wide_cy)
    );

    // Opcode decode; the half-select bit sits at a different place per form
    always_comb begin
        dec_op = OP_ILLEGAL;
        dec_hi = 1'b0;
        if ((HWDATA[15:0] & MSK_AND_TO_MEM) == PAT_AND_TO_MEM) begin
            dec_op = OP_AND_TO_MEM;
            dec_hi = HWDATA[HI_BIT_AND];
        end else if ((HWDATA[15:0] & MSK_AND_TO_HALF) == PAT_AND_TO_HALF) begin
            dec_op = OP_AND_TO_HALF;
            dec_hi = HWDATA[HI_BIT_AND];
        end else if ((HWDATA[15:0] & MSK_AND_IMM_MEM) == PAT_AND_IMM_MEM) begin
            dec_op = OP_AND_IMM_MEM;
        end else if ((HWDATA[15:0] & MSK_AND_BYTE) == PAT_AND_BYTE) begin
            dec_op = OP_AND_BYTE;
            dec_hi = HWDATA[HI_BIT_AND];
        end else if (HWDATA[15:0] == PAT_ALIGN) begin
            dec_op = OP_ALIGN;
        end else if ((HWDATA[15:0] & MSK_ASR_IMM) == PAT_ASR_IMM) begin
            dec_op = OP_ASR_IMM;
            dec_hi = HWDATA[HI_BIT_ASR_IMM];
        end else if ((HWDATA[15:0] & MSK_ASR_CNT) == PAT_ASR_CNT) begin
            dec_op = OP_ASR_CNT;
            dec_hi = HWDATA[HI_BIT_ASR_CNT];
        end else if ((HWDATA[15:0] & MSK_ASR_WIDE) == PAT_ASR_WIDE) begin
            dec_op = OP_ASR_WIDE;
        end
    end

    // Register read view
    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (addr_reg)
            OFS_OPCODE: read_mux = {16'h0000, opcode_reg};
            OFS_IMMW:   read_mux = {16'h0000, immw_reg};
            OFS_MEMOP:  read_mux = {16'h0000, memop_reg};
            OFS_ACC:    read_mux = acc_reg;
            OFS_PROD:   read_mux = prod_reg;
            OFS_MCAND:  read_mux = multiplicand_full_reg;
            OFS_SP:     read_mux = {16'h0000, sp_reg};
            OFS_STATUS: read_mux = {26'h000_0000, ill_reg, (d1_op_reg != OP_NONE),
                                    stack_align_flag_reg, n_reg, z_reg, c_reg};
            OFS_REPEAT: read_mux = {16'h0000, repeat_counter_reg};
            default:    read_mux = 32'h0000_0000;
        endcase
    end

    // Bus next state: reads take one wait state so data always reflect latest writes
    always_comb begin
        wr_pend_next = wr_pend_reg;
        rd_pend_next = rd_pend_reg;
        addr_next    = addr_reg;
        ready_next   = ready_reg;
        rdata_next   = rdata_reg;
        if (CE) begin
            wr_pend_next = accept & HWRITE;
            rd_pend_next = accept & ~HWRITE;
            ready_next   = ~(accept & ~HWRITE);
            if (accept) begin
                addr_next = HADDR[7:0];
            end
            if (rd_pend_reg) begin
                rdata_next = read_mux;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            ready_reg   <= 1'b1;
            rdata_reg   <= 32'h0000_0000;
            resp_reg    <= RESP_OKAY;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg    <= addr_next;
            ready_reg   <= ready_next;
            rdata_reg   <= rdata_next;
            resp_reg    <= RESP_OKAY;
        end
    end

    assign HRDATA    = rdata_reg;
    assign HREADYOUT = ready_reg;
    assign HRESP     = resp_reg;

    // Decode stage: opcode write fills stage one, commit happens on the next edge
    always_comb begin
        d1_op_next  = d1_op_reg;
        d1_hi_next  = d1_hi_reg;
        opcode_next = opcode_reg;
        if (fire) begin
            d1_op_next = OP_NONE;
        end
        if (op_wr) begin
            d1_op_next  = dec_op;
            d1_hi_next  = dec_hi;
            opcode_next = HWDATA[15:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            d1_op_reg  <= OP_NONE;
            d1_hi_reg  <= 1'b0;
            opcode_reg <= RST_OPCODE;
        end else begin
            d1_op_reg  <= d1_op_next;
            d1_hi_reg  <= d1_hi_next;
            opcode_reg <= opcode_next;
        end
    end

    // Architectural next state: bus writes first, execution after so it wins a clash
    always_comb begin
        acc_next   = acc_reg;
        prod_next  = prod_reg;
        multiplicand_full_next = multiplicand_full_reg;
        sp_next    = sp_reg;
        memop_next = memop_reg;
        immw_next  = immw_reg;
        repeat_counter_next = repeat_counter_reg;
        c_next     = c_reg;
        z_next     = z_reg;
        n_next     = n_reg;
        stack_align_flag_next = stack_align_flag_reg;
        ill_next   = ill_reg;
        and_res    = 16'h0000;
        if (bus_wr) begin
            unique case (addr_reg)
                OFS_IMMW:   immw_next  = HWDATA[15:0];
                OFS_MEMOP:  memop_next = HWDATA[15:0];
                OFS_ACC:    acc_next   = HWDATA;
                OFS_PROD:   prod_next  = HWDATA;
                OFS_MCAND:  multiplicand_full_next = HWDATA;
                OFS_SP:     sp_next    = HWDATA[15:0];
                OFS_REPEAT: repeat_counter_next = HWDATA[15:0];
                OFS_STATUS: begin
                    c_next   = HWDATA[ST_C];
                    z_next   = HWDATA[ST_Z];
                    n_next   = HWDATA[ST_N];
                    stack_align_flag_next = HWDATA[ST_ALIGN];
                    ill_next = HWDATA[ST_ILL];
                end
                default: ;
            endcase
        end
        if (fire) begin
            // Not repeatable: a pending repeat count is dropped, except on an illegal opcode
            repeat_counter_next = RST_REPEAT;
            unique case (d1_op_reg)
                OP_AND_TO_MEM, OP_AND_IMM_MEM: begin
                    // Single-cycle commit keeps the read-modify-write indivisible
                    and_res    = memop_reg & ((d1_op_reg == OP_AND_TO_MEM) ?
                                              half_cur : immw_reg);
                    memop_next = and_res;
                    n_next     = and_res[15];
                    z_next     = (and_res == 16'h0000);
                end
                OP_AND_TO_HALF, OP_AND_BYTE, OP_ASR_IMM, OP_ASR_CNT: begin
                    if (d1_op_reg == OP_AND_TO_HALF) begin
                        and_res = half_cur & memop_reg;
                    end else if (d1_op_reg == OP_AND_BYTE) begin
                        and_res = half_cur & {8'h00, opcode_reg[7:0]};
                    end else begin
                        and_res = half_shr;
                        c_next  = half_cy;
                    end
                    // Only the selected half changes
                    acc_next = d1_hi_reg ? {and_res, acc_reg[15:0]} :
                                           {acc_reg[31:16], and_res};
                    n_next   = and_res[15];
                    z_next   = (and_res == 16'h0000);
                end
                OP_ALIGN: begin
                    // Flag change lands on the second-stage edge
                    if (sp_reg[0]) begin
                        sp_next  = sp_reg + 16'h0001;
                        stack_align_flag_next = 1'b1;
                    end else begin
                        stack_align_flag_next = 1'b0;
                    end
                end
                OP_ASR_WIDE: begin
                    acc_next  = wide_shr[63:32];
                    prod_next = wide_shr[31:0];
                    c_next    = wide_cy;
                    n_next    = wide_shr[63];
                    z_next    = (wide_shr == 64'h0000_0000_0000_0000);
                end
                OP_ILLEGAL: begin
                    repeat_counter_next = repeat_counter_reg;
                    ill_next  = 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_reg   <= RST_ACC;
            prod_reg  <= RST_PROD;
            multiplicand_full_reg <= RST_MCAND;
            sp_reg    <= RST_SP;
            memop_reg <= RST_MEMOP;
            immw_reg  <= RST_IMMW;
            repeat_counter_reg <= RST_REPEAT;
            c_reg     <= 1'b0;
            z_reg     <= 1'b0;
            n_reg     <= 1'b0;
            stack_align_flag_reg <= 1'b0;
            ill_reg   <= 1'b0;
        end else begin
            acc_reg   <= acc_next;
            prod_reg  <= prod_next;
            multiplicand_full_reg <= multiplicand_full_next;
            sp_reg    <= sp_next;
            memop_reg <= memop_next;
            immw_reg  <= immw_next;
            repeat_counter_reg <= repeat_counter_next;
            c_reg     <= c_next;
            z_reg     <= z_next;
            n_reg     <= n_next;
            stack_align_flag_reg <= stack_align_flag_next;
            ill_reg   <= ill_next;
        end
    end

    // Checks on the committed results
    a_and_mem_rmw: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_AND_TO_MEM |=>
        memop_reg == ($past(memop_reg) & $past(half_cur)))
        else $error("memory AND result wrong");

    a_mem_flags: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && (d1_op_reg == OP_AND_TO_MEM || d1_op_reg == OP_AND_IMM_MEM) |=>
        n_reg == memop_reg[15] && z_reg == (memop_reg == 16'h0000))
        else $error("memory result flags wrong");

    a_half_and: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_AND_TO_HALF |=>
        ($past(d1_hi_reg) ? acc_reg[31:16] : acc_reg[15:0]) ==
        ($past(half_cur) & $past(memop_reg)) && memop_reg == $past(memop_reg))
        else $error("half AND result wrong");

    a_half_flags: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && (d1_op_reg inside {OP_AND_TO_HALF, OP_AND_BYTE, OP_ASR_IMM, OP_ASR_CNT}) |=>
        n_reg == ($past(d1_hi_reg) ? acc_reg[31] : acc_reg[15]) &&
        z_reg == (($past(d1_hi_reg) ? acc_reg[31:16] : acc_reg[15:0]) == 16'h0000))
        else $error("half result flags wrong");

    a_imm_mem: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_AND_IMM_MEM |=>
        memop_reg == ($past(memop_reg) & $past(immw_reg)) && acc_reg == $past(acc_reg))
        else $error("immediate memory AND wrong");

    a_byte_zext: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_AND_BYTE |=>
        ($past(d1_hi_reg) ? acc_reg[31:16] : acc_reg[15:0]) ==
        {8'h00, $past(half_cur[7:0]) & $past(opcode_reg[7:0])})
        else $error("byte AND not zero extended");

    a_other_half: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && (d1_op_reg inside {OP_AND_TO_HALF, OP_AND_BYTE, OP_ASR_IMM, OP_ASR_CNT}) |=>
        ($past(d1_hi_reg) ? acc_reg[15:0] == $past(acc_reg[15:0]) :
                            acc_reg[31:16] == $past(acc_reg[31:16])))
        else $error("unselected half changed");

    a_align_odd: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_ALIGN |=>
        stack_align_flag_reg == $past(sp_reg[0]) &&
        sp_reg == ($past(sp_reg[0]) ? $past(sp_reg) + 16'h0001 : $past(sp_reg)))
        else $error("stack align wrong");

    a_align_stage: assert property (@(posedge CLK) disable iff (!RESET_N)
        op_wr && HWDATA[15:0] == PAT_ALIGN ##1 CE |=> stack_align_flag_reg == $past(sp_reg[0]))
        else $error("align flag not at second stage");

    a_asr_imm: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_ASR_IMM |=>
        c_reg == $past(half_cur[opcode_reg[3:0]]) &&
        ($past(d1_hi_reg) ? acc_reg[31] : acc_reg[15]) == $past(half_cur[15]))
        else $error("immediate half shift wrong");

    a_cnt_shift: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_ASR_CNT |=>
        ($past(d1_hi_reg) ? acc_reg[31:16] : acc_reg[15:0]) ==
        16'($signed($past(half_cur)) >>> $past(multiplicand_full_reg[19:16])))
        else $error("count half shift wrong");

    a_cnt_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_ASR_CNT && multiplicand_full_reg[19:16] == 4'h0 |=>
        !c_reg && z_reg == ($past(half_cur) == 16'h0000) && n_reg == $past(half_cur[15]))
        else $error("zero count flags wrong");

    a_wide_shift: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg == OP_ASR_WIDE |=>
        c_reg == $past(prod_reg[opcode_reg[3:0]]) && acc_reg[31] == $past(acc_reg[31]) &&
        n_reg == acc_reg[31] && z_reg == ({acc_reg, prod_reg} == 64'h0))
        else $error("wide shift wrong");

    a_no_repeat: assert property (@(posedge CLK) disable iff (!RESET_N)
        fire && d1_op_reg != OP_ILLEGAL |=> repeat_counter_reg == 16'h0000)
        else $error("repeat counter not cleared");
endmodule

// File: tb/logic_shift_stack_align_ops_test.sv
// Bus-driven testbench for the AND, stack-align and shift execution block
`timescale 1ns/1ps
module logic_shift_stack_align_ops_test
    import lssa_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    int          n_fail = 0;
    int          n_checks = 0;

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // Single slave, so its ready is the bus ready
    lssa_core i_dut (.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One transfer; the address phase is held until ready, then the data phase
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk iff hreadyout === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk iff hreadyout === 1'b1);
        q = hrdata;
        // Every transfer must end with an OKAY answer
        check("hresp", {31'h0000_0000, hresp}, {31'h0000_0000, RESP_OKAY});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        check(name, q, exp);
    endtask

    // Issue an opcode, then read back the result and the low status bits
    task automatic op(input logic [15:0] opc, input logic [7:0] ra, input logic [31:0] er,
                      input logic [5:0] ef);
        logic [31:0] q;
        wr(OFS_OPCODE, {16'h0000, opc});
        rd("result", ra, er);
        xfer(1'b0, OFS_STATUS, 32'h0000_0000, q);
        check("status", {26'h000_0000, q[5:0]}, {26'h000_0000, ef});
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog; the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    // Main sequence; status expectations carry C over where an op leaves it
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd("acc reset", OFS_ACC, RST_ACC);
        rd("unmapped", 8'h40, 32'h0000_0000);
        wr(OFS_ACC, 32'h8F00_F0F0);
        wr(OFS_MEMOP, 32'h0000_00FF);
        wr(OFS_REPEAT, 32'h0000_0005);
        op(PAT_AND_TO_MEM, OFS_MEMOP, 32'h0000_00F0, 6'h00);
        rd("repeat", OFS_REPEAT, 32'h0000_0000);
        wr(OFS_MEMOP, 32'h0000_F0F0);
        op(PAT_AND_TO_HALF | 16'h0100, OFS_ACC, 32'h8000_F0F0, 6'h04);
        wr(OFS_IMMW, 32'h0000_00F0);
        wr(OFS_MEMOP, 32'h0000_0F0F);
        op(PAT_AND_IMM_MEM, OFS_MEMOP, 32'h0000_0000, 6'h02);
        op(PAT_AND_BYTE | 16'h00FF, OFS_ACC, 32'h8000_00F0, 6'h00);
        op(PAT_ASR_IMM | 16'h0004, OFS_ACC, 32'h8000_0007, 6'h01);
        op(PAT_ASR_IMM | 16'h001F, OFS_ACC, 32'hFFFF_0007, 6'h05);
        wr(OFS_MCAND, 32'hFFF0_0000);
        op(PAT_ASR_CNT, OFS_ACC, 32'hFFFF_0007, 6'h00);
        wr(OFS_ACC, 32'h000C_0007);
        wr(OFS_MCAND, 32'hFFF3_0000);
        op(PAT_ASR_CNT | 16'h0001, OFS_ACC, 32'h0001_0007, 6'h01);
        wr(OFS_ACC, 32'h8000_0000);
        wr(OFS_PROD, 32'h0000_0001);
        op(PAT_ASR_WIDE, OFS_ACC, 32'hC000_0000, 6'h05);
        rd("prod", OFS_PROD, 32'h0000_0000);
        wr(OFS_ACC, 32'h0000_0000);
        wr(OFS_PROD, 32'h0000_7FFF);
        op(PAT_ASR_WIDE | 16'h000F, OFS_PROD, 32'h0000_0000, 6'h02);
        wr(OFS_SP, 32'h0000_0003);
        op(PAT_ALIGN, OFS_SP, 32'h0000_0004, 6'h0A);
        op(PAT_ALIGN, OFS_SP, 32'h0000_0004, 6'h02);
        // Unknown opcode: only the illegal bit rises, repeat count is kept
        wr(OFS_REPEAT, 32'h0000_0007);
        op(16'h0000, OFS_REPEAT, 32'h0000_0007, 6'h22);
        complete_run();
    end
endmodule
